// >>> rtl/rsa_pkg.sv
// reset source arbiter: shared constants, reset kinds and sequencer states
// assumes a single system clock; watchdog oscillator arrives as a sampled level
package rsa_pkg;

  localparam int unsigned CNT_W = 10;

  // reset lengths, in watchdog-oscillator cycles and then system clocks
  localparam logic [CNT_W-1:0] WDT_CYC_SYSTEM  = 10'h202;
  localparam logic [CNT_W-1:0] WDT_CYC_SHORT   = 10'h042;
  localparam logic [CNT_W-1:0] SYSCLK_CYC_TAIL = 10'h010;
  localparam logic [CNT_W-1:0] CNT_LAST        = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO        = 10'h000;

  // reset vector location in program memory, high byte first
  localparam logic [15:0] VEC_ADDR_HI = 16'h0002;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0003;

  typedef enum logic [1:0] {
    RSA_NONE,
    RSA_SHORT,
    RSA_SYSTEM,
    RSA_SYS_KEEP_OCD
  } rsa_rtype_e;

  typedef enum logic [2:0] {
    RSA_IDLE,
    RSA_WDT,
    RSA_SYS,
    RSA_FHI,
    RSA_FLO,
    RSA_LOAD
  } rsa_state_e;

endpackage : rsa_pkg

// >>> rtl/rsa_reset_source_arbiter.sv
// reset source arbiter: picks the reset kind per source and operating mode,
// times the reset and fetches the reset vector for the processor.
// assumes a synchronous program memory (data one clock after address) and
// that pins and the watchdog domain arrive asynchronously.
//
// Functional notes
// - power-on/brown-out beats every other source, full reset
// - normal/halt: power-on/brown-out gives full system reset
// - normal/halt: watchdog-reset or reset pin gives short
// - debugger control bit1: system reset, debugger kept
// - stop: power-on, reset pin, debug low: full
// - system reset: 514 oscillator then 16 clocks
// - short reset: only 66 oscillator cycles first
// - core idle; system clock starts after oscillator count
// - leave reset by loading vector from 0002H/0003H
`timescale 1ns/10ps

module rsa_reset_source_arbiter #(
  parameter logic [rsa_pkg::CNT_W-1:0] LONG_CYC  = rsa_pkg::WDT_CYC_SYSTEM,
  parameter logic [rsa_pkg::CNT_W-1:0] SHORT_CYC = rsa_pkg::WDT_CYC_SHORT,
  parameter logic [rsa_pkg::CNT_W-1:0] TAIL_CYC  = rsa_pkg::SYSCLK_CYC_TAIL
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        por_bod_in,
  input  wire logic        wdt_osc_in,
  input  wire logic        wdt_timeout_in,
  input  wire logic        wdt_reset_mode_in,
  input  wire logic        ext_reset_n_in,
  input  wire logic        ocd_reset_req_in,
  input  wire logic        debug_serial_pin_in,
  input  wire logic        stop_mode_in,
  input  wire logic [7:0]  prog_data_in,
  output logic             core_reset_out,
  output logic             ocd_reset_out,
  output logic             sys_clk_run_out,
  output logic [1:0]       reset_type_out,
  output logic             prog_rd_out,
  output logic [15:0]      prog_addr_out,
  output logic [15:0]      pc_out,
  output logic             pc_load_out
);

  typedef struct packed {
    rsa_pkg::rsa_state_e         state;
    logic [rsa_pkg::CNT_W-1:0]   cnt;
    rsa_pkg::rsa_rtype_e         rtype;
    logic [1:0]                  s_por;
    logic [2:0]                  s_osc;
    logic [1:0]                  s_wdt;
    logic [1:0]                  s_ext;
    logic [1:0]                  s_dbg;
    logic [7:0]                  vec_hi;
    logic [15:0]                 pc;
    logic                        pc_load;
  } rsa_st_s;

  rsa_st_s             st_reg;
  rsa_st_s             st_next;
  rsa_pkg::rsa_rtype_e req;
  logic                por_s;
  logic                ext_s;
  logic                dbg_low_s;
  logic                wdt_s;
  logic                osc_tick;
  logic                in_reset;

  // only the second stage of each synchroniser is looked at, plus the third for the oscillator edge
  assign por_s     = st_reg.s_por[1];
  assign ext_s     = ~st_reg.s_ext[1];
  assign dbg_low_s = ~st_reg.s_dbg[1];
  assign wdt_s     = st_reg.s_wdt[1];
  assign osc_tick  = st_reg.s_osc[1] & ~st_reg.s_osc[2];
  assign in_reset  = (st_reg.state == rsa_pkg::RSA_WDT) || (st_reg.state == rsa_pkg::RSA_SYS);

  always_comb begin
    req = rsa_pkg::RSA_NONE;
    if (por_s) begin
      req = rsa_pkg::RSA_SYSTEM;
    end else if (stop_mode_in) begin
      // watchdog and debugger requests do not reset from stop
      if (ext_s || dbg_low_s) begin
        req = rsa_pkg::RSA_SYSTEM;
      end
    end else if (ocd_reset_req_in) begin
      req = rsa_pkg::RSA_SYS_KEEP_OCD;
    end else if ((wdt_s && wdt_reset_mode_in) || ext_s) begin
      req = rsa_pkg::RSA_SHORT;
    end
  end

  always_comb begin
    st_next         = st_reg;
    st_next.pc_load = 1'b0;
    st_next.s_por   = {st_reg.s_por[0], por_bod_in};
    st_next.s_osc   = {st_reg.s_osc[1:0], wdt_osc_in};
    st_next.s_wdt   = {st_reg.s_wdt[0], wdt_timeout_in};
    st_next.s_ext   = {st_reg.s_ext[0], ext_reset_n_in};
    st_next.s_dbg   = {st_reg.s_dbg[0], debug_serial_pin_in};
    if (por_s) begin
      // held power-on keeps reloading, so the count runs from its release
      st_next.state = rsa_pkg::RSA_WDT;
      st_next.cnt   = LONG_CYC;
      st_next.rtype = rsa_pkg::RSA_SYSTEM;
    end else if (!in_reset && (req != rsa_pkg::RSA_NONE)) begin
      st_next.state = rsa_pkg::RSA_WDT;
      st_next.rtype = req;
      st_next.cnt   = (req == rsa_pkg::RSA_SHORT) ? SHORT_CYC : LONG_CYC;
    end else begin
      case (st_reg.state)
        rsa_pkg::RSA_WDT: begin
          if (osc_tick) begin
            if (st_reg.cnt == rsa_pkg::CNT_LAST) begin
              st_next.state = rsa_pkg::RSA_SYS;
              st_next.cnt   = TAIL_CYC;
            end else begin
              st_next.cnt = st_reg.cnt - rsa_pkg::CNT_LAST;
            end
          end
        end
        rsa_pkg::RSA_SYS: begin
          if (st_reg.cnt == rsa_pkg::CNT_LAST) begin
            st_next.state = rsa_pkg::RSA_FHI;
            st_next.cnt   = rsa_pkg::CNT_ZERO;
          end else begin
            st_next.cnt = st_reg.cnt - rsa_pkg::CNT_LAST;
          end
        end
        rsa_pkg::RSA_FHI: begin
          st_next.state = rsa_pkg::RSA_FLO;
        end
        rsa_pkg::RSA_FLO: begin
          st_next.vec_hi = prog_data_in;
          st_next.state  = rsa_pkg::RSA_LOAD;
        end
        rsa_pkg::RSA_LOAD: begin
          st_next.pc      = {st_reg.vec_hi, prog_data_in};
          st_next.pc_load = 1'b1;
          st_next.state   = rsa_pkg::RSA_IDLE;
          st_next.rtype   = rsa_pkg::RSA_NONE;
        end
        default: begin
          st_next.state = rsa_pkg::RSA_IDLE;
        end
      endcase
    end
  end

  // pins start at their idle levels so reset release is not seen as a source
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_reg         <= '0;
      st_reg.state   <= rsa_pkg::RSA_IDLE;
      st_reg.rtype   <= rsa_pkg::RSA_NONE;
      st_reg.s_ext   <= 2'h3;
      st_reg.s_dbg   <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // core stays idle until the vector is loaded
  assign core_reset_out  = (st_reg.state != rsa_pkg::RSA_IDLE);
  assign ocd_reset_out   = in_reset && (st_reg.rtype != rsa_pkg::RSA_SYS_KEEP_OCD);
  assign sys_clk_run_out = (st_reg.state != rsa_pkg::RSA_WDT);
  assign reset_type_out  = st_reg.rtype;
  assign prog_rd_out     = (st_reg.state == rsa_pkg::RSA_FHI) || (st_reg.state == rsa_pkg::RSA_FLO);
  assign prog_addr_out   = (st_reg.state == rsa_pkg::RSA_FLO) ? rsa_pkg::VEC_ADDR_LO : rsa_pkg::VEC_ADDR_HI;
  assign pc_out          = st_reg.pc;
  assign pc_load_out     = st_reg.pc_load;

  // oscillator ticks seen in the current first phase, for checking only
  logic [rsa_pkg::CNT_W-1:0] chk_ticks;
  always_ff @(posedge clock_in) begin
    if (rst_in || por_s || (st_reg.state != rsa_pkg::RSA_WDT)) begin
      chk_ticks <= rsa_pkg::CNT_ZERO;
    end else if (osc_tick) begin
      chk_ticks <= chk_ticks + rsa_pkg::CNT_LAST;
    end
  end

  // cycles spent in the system-clock tail, for checking only
  logic [rsa_pkg::CNT_W-1:0] chk_tail;
  always_ff @(posedge clock_in) begin
    if (rst_in || (st_reg.state != rsa_pkg::RSA_SYS)) begin
      chk_tail <= rsa_pkg::CNT_ZERO;
    end else begin
      chk_tail <= chk_tail + rsa_pkg::CNT_LAST;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_POR_WINS: assert property (por_s |=> (st_reg.rtype == rsa_pkg::RSA_SYSTEM)
    && (st_reg.state == rsa_pkg::RSA_WDT) && ocd_reset_out)
    else $error("power-on did not force a full reset");

  AST_STOP_FULL: assert property (stop_mode_in && (ext_s || dbg_low_s) && !in_reset
    |=> st_reg.rtype == rsa_pkg::RSA_SYSTEM)
    else $error("stop-mode source did not give a full reset");

  AST_NORMAL_SHORT: assert property (!stop_mode_in && !por_s && !ocd_reset_req_in
    && ext_s && !in_reset |=> st_reg.rtype == rsa_pkg::RSA_SHORT)
    else $error("reset pin in normal mode did not give a short reset");

  AST_WDT_IRQ_MODE: assert property ((st_reg.state == rsa_pkg::RSA_IDLE) && wdt_s
    && !wdt_reset_mode_in && !ext_s && !por_s && !ocd_reset_req_in && !stop_mode_in
    |=> st_reg.state == rsa_pkg::RSA_IDLE)
    else $error("watchdog in interrupt mode caused a reset");

  AST_OCD_KEPT: assert property (!stop_mode_in && !por_s && ocd_reset_req_in && !in_reset
    |=> (st_reg.rtype == rsa_pkg::RSA_SYS_KEEP_OCD) && core_reset_out && !ocd_reset_out)
    else $error("debugger reset touched the debugger");

  AST_FIRST_PHASE: assert property ((st_reg.state == rsa_pkg::RSA_WDT) && osc_tick
    && (st_reg.cnt == rsa_pkg::CNT_LAST) && !por_s
    |-> chk_ticks == (((st_reg.rtype == rsa_pkg::RSA_SHORT) ? SHORT_CYC : LONG_CYC) - rsa_pkg::CNT_LAST))
    else $error("oscillator phase length wrong");

  // counted by a helper so the check follows a shortened tail as well
  sequence s_tail_last;
    (st_reg.state == rsa_pkg::RSA_SYS) && (st_reg.cnt == rsa_pkg::CNT_LAST) && !por_s;
  endsequence
  AST_TAIL_LEN: assert property (s_tail_last |-> (chk_tail == TAIL_CYC - rsa_pkg::CNT_LAST)
    ##1 (st_reg.state == rsa_pkg::RSA_FHI))
    else $error("system-clock tail length wrong");

  AST_CLK_HELD: assert property ((st_reg.state == rsa_pkg::RSA_WDT)
    && !(osc_tick && (st_reg.cnt == rsa_pkg::CNT_LAST))
    |=> (st_reg.state == rsa_pkg::RSA_WDT) && !sys_clk_run_out && core_reset_out)
    else $error("system clock started before oscillator count ended");

  sequence s_fetch;
    (st_reg.state == rsa_pkg::RSA_FLO) ##1 ((st_reg.state == rsa_pkg::RSA_LOAD) && (req == rsa_pkg::RSA_NONE));
  endsequence
  AST_VECTOR: assert property (s_fetch |=> pc_load_out && !core_reset_out
    && (pc_out == {$past(prog_data_in, 2), $past(prog_data_in)}))
    else $error("reset vector not loaded from program memory");

  AST_NO_SHORTEN: assert property (in_reset && !por_s
    |=> st_reg.rtype == $past(st_reg.rtype))
    else $error("reset kind changed during an active reset");

endmodule : rsa_reset_source_arbiter

// >>> bench/rsa_far_model.sv
// far side: free-running watchdog oscillator and program memory with the vector
// assumes memory data one clock after address, as the arbiter expects
`timescale 1ns/10ps
module rsa_far_model #(
  parameter logic [15:0] VEC  = 16'h5A3C,
  parameter int          HALF = 4
) (
  input  wire logic        clock_in,
  input  wire logic        prog_rd_in,
  input  wire logic [15:0] prog_addr_in,
  output logic             wdt_osc_out,
  output logic [7:0]       prog_data_out
);
  int ph = 0;
  initial wdt_osc_out = 1'b0;
  initial prog_data_out = 8'h00;
  // keeps running through reset
  always @(negedge clock_in) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) wdt_osc_out <= ~wdt_osc_out;
  end
  // high byte at 0002H, low at 0003H; idle bus keeps changing
  always @(posedge clock_in) begin
    if (prog_rd_in && prog_addr_in == 16'h0002) prog_data_out <= VEC[15:8];
    else if (prog_rd_in && prog_addr_in == 16'h0003) prog_data_out <= VEC[7:0];
    else prog_data_out <= ~prog_data_out;
  end
endmodule : rsa_far_model

// >>> bench/tb.sv
// bench for the reset source arbiter with shortened counts
// assumes the far model above; inputs change at the falling edge
`timescale 1ns/10ps
module tb;
  localparam logic [9:0]  LC  = 10'h006;
  localparam logic [9:0]  SC  = 10'h003;
  localparam logic [9:0]  TC  = 10'h004;
  localparam logic [15:0] VEC = 16'h5A3C;
  logic clock_in = 1'b0, rst_in = 1'b1, por = 1'b0, wto = 1'b0, wmode = 1'b1;
  logic ext_n = 1'b1, ocd = 1'b0, dbg = 1'b1, stop = 1'b0;
  logic core_rst, ocd_rst, clk_run, prd, pcl, osc;
  logic [1:0]  rtype;
  logic [7:0]  pdata;
  logic [15:0] paddr, pc;
  int bad_count = 0, cmp_count = 0, osc_cnt = 0;
  always #25 clock_in = ~clock_in;
  // counts rising oscillator edges seen in the first phase only
  always @(posedge osc) if (core_rst === 1'b1 && clk_run === 1'b0) osc_cnt++;
  rsa_reset_source_arbiter #(.LONG_CYC(LC), .SHORT_CYC(SC), .TAIL_CYC(TC)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .por_bod_in(por), .wdt_osc_in(osc),
    .wdt_timeout_in(wto), .wdt_reset_mode_in(wmode), .ext_reset_n_in(ext_n),
    .ocd_reset_req_in(ocd), .debug_serial_pin_in(dbg), .stop_mode_in(stop),
    .prog_data_in(pdata), .core_reset_out(core_rst), .ocd_reset_out(ocd_rst),
    .sys_clk_run_out(clk_run), .reset_type_out(rtype), .prog_rd_out(prd),
    .prog_addr_out(paddr), .pc_out(pc), .pc_load_out(pcl));
  rsa_far_model #(.VEC(VEC), .HALF(4)) FAR (.clock_in(clock_in), .prog_rd_in(prd),
    .prog_addr_in(paddr), .wdt_osc_out(osc), .prog_data_out(pdata));
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; s !== 1'b1; i++) begin
      if (i == lim) begin
        bad_count++;
        $display("ERROR wait expected 1 seen 0");
        results();
      end
      @(posedge clock_in);
      #1;
    end
  endtask : wait_hi
  task automatic src(input int s, input logic on);
    case (s)
      0: por = on;
      1: ext_n = ~on;
      2: dbg = ~on;
      3: wto = on;
      default: ocd = on;
    endcase
  endtask : src
  // ocd request is a one-cycle pulse, others are held four cycles
  task automatic kick(input int s);
    @(negedge clock_in) src(s, 1'b1);
    repeat ((s == 4) ? 1 : 4) @(negedge clock_in);
    src(s, 1'b0);
  endtask : kick
  task automatic run_reset(input logic [1:0] t, input logic o, input int n);
    int k;
    wait_hi(core_rst, 12);
    cmp("reset_type", t, rtype);
    cmp("clk_run", 1'b0, clk_run);
    wait_hi(clk_run, 8 * n + 40);
    cmp("osc_count_ok", 1'b1, osc_cnt >= n - 1 && osc_cnt <= n + 1);
    cmp("ocd_reset", o, ocd_rst);
    for (k = 0; prd !== 1'b1 && k < 40; k++) begin
      @(posedge clock_in);
      #1;
      cmp("core_reset", 1'b1, core_rst);
    end
    cmp("tail", 16'(TC), 16'(k));
    cmp("addr_hi", 16'h0002, paddr);
    cmp("ocd_reset_fetch", 1'b0, ocd_rst);
    @(posedge clock_in);
    #1;
    cmp("addr_lo", 16'h0003, paddr);
    cmp("prog_rd_lo", 1'b1, prd);
    wait_hi(pcl, 4);
    cmp("pc", VEC, pc);
    cmp("core_reset", 1'b0, core_rst);
    cmp("reset_type_end", 2'h0, rtype);
    cmp("clk_run_end", 1'b1, clk_run);
    @(posedge clock_in);
    #1;
    cmp("pc_load_pulse", 1'b0, pcl);
    osc_cnt = 0;
  endtask : run_reset
  task automatic t_normal();
    kick(1);
    run_reset(2'h1, 1'b1, SC);
    kick(3);
    run_reset(2'h1, 1'b1, SC);
    kick(0);
    run_reset(2'h2, 1'b1, LC);
    kick(4);
    run_reset(2'h3, 1'b0, LC);
    $display("test normal done");
  endtask : t_normal
  task automatic t_stop();
    @(negedge clock_in);
    stop = 1'b1;
    for (int s = 0; s < 3; s++) begin
      kick(s);
      run_reset(2'h2, 1'b1, LC);
    end
    @(negedge clock_in);
    stop = 1'b0;
    $display("test stop done");
  endtask : t_stop
  // late sources: ocd must not change a short reset, power-on must win
  task automatic t_late();
    kick(1);
    repeat (6) @(negedge clock_in);
    kick(4);
    run_reset(2'h1, 1'b1, SC);
    kick(1);
    repeat (6) @(negedge clock_in);
    kick(0);
    osc_cnt = 0;
    run_reset(2'h2, 1'b1, LC);
    $display("test late done");
  endtask : t_late
  task automatic t_refuse();
    @(negedge clock_in);
    stop = 1'b1;
    kick(3);
    kick(4);
    cmp("core_reset_stop", 1'b0, core_rst);
    stop = 1'b0;
    wmode = 1'b0;
    kick(3);
    repeat (8) @(negedge clock_in);
    cmp("core_reset", 1'b0, core_rst);
    wmode = 1'b1;
    $display("test refuse done");
  endtask : t_refuse
  initial begin
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    t_normal();
    t_stop();
    t_late();
    t_refuse();
    results();
  end
endmodule : tb
